// ==== common/hap_if.sv ====
// two-wire serial link joining the controller and its master
`timescale 1ns/1ps
interface hap_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic scl_s_o;
  logic scl_s_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // wired-and with pull-ups
  assign scl = !((scl_m_oe & !scl_m_o) | (scl_s_oe & !scl_s_o));
  assign sda = !((sda_m_oe & !sda_m_o) | (sda_s_oe & !sda_s_o));
  modport dev (input scl, input sda, output scl_s_o, output scl_s_oe,
               output sda_s_o, output sda_s_oe);
  modport host (input scl, input sda, output scl_m_o, output scl_m_oe,
                output sda_m_o, output sda_m_oe);
endinterface

// ==== common/hap_pkg.sv ====
// shared constants for the haptic command controller and its bus master
package hap_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam logic [6:0] SLAVE_ADDR = 7'h10;
  localparam logic [7:0] CMD_EFFECT = 8'h01;
  localparam logic [7:0] CMD_ABORT = 8'h02;
  localparam logic [7:0] CMD_REV = 8'h03;
  localparam logic [3:0] NUM_EFFECTS = 4'hD;
  // revision answer; the value is arbitrary
  localparam logic [15:0] REV_VALUE = 16'h0102;
  localparam logic [9:0] DUTY_MID = 10'h200;
  // serial rates and the master's quarter-bit timing
  localparam int unsigned STD_HZ = 100_000;
  localparam int unsigned FAST_HZ = 400_000;
  localparam logic [8:0] QTR_STD = 9'(CLK_HZ / (4 * STD_HZ));
  localparam logic [8:0] QTR_FAST = 9'(CLK_HZ / (4 * FAST_HZ));
  // clock stretch hold and its time-out
  localparam int unsigned STRETCH_NS = 1000;
  localparam logic [23:0] STRETCH_CYC = 24'(STRETCH_NS / 5);
  localparam int unsigned STRETCH_TO_US = 25_000;
  localparam int unsigned STRETCH_TO_CYC = STRETCH_TO_US * (CLK_HZ / 1_000_000);
  // vibration and pwm carrier
  localparam int unsigned VIB_HZ = 200;
  localparam int unsigned VIB_HALF_CYC = CLK_HZ / (2 * VIB_HZ);
  localparam logic [3:0] PWM_DIV = 4'h4;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK, D_RX, D_STRETCH, D_TX, D_MACK} hap_dst_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_RSTART} hap_hst_t;
endpackage

// ==== hdl/hap_dev.sv ====
// haptic controller end: serial slave, command decode and effect drive
`timescale 1ns/1ps
module hap_dev
  import hap_pkg::*;
#(
  parameter int unsigned STRETCH_TO = hap_pkg::STRETCH_TO_CYC,
  parameter int unsigned VIB_HALF = hap_pkg::VIB_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  hap_if.dev bus,
  output logic o_pwm_drive_true,
  output logic o_pwm_drive_inverted,
  output logic o_effect_busy
);
  hap_dst_t state_r;
  logic scl_m_r;
  logic scl_s_r;
  logic scl_d_r;
  logic sda_m_r;
  logic sda_s_r;
  logic sda_d_r;
  logic [7:0] shift_r;
  logic [3:0] bit_r;
  logic rw_r;
  logic [1:0] nbytes_r;
  logic [7:0] cmd0_r;
  logic [7:0] cmd1_r;
  logic [15:0] tx_r;
  logic more_r;
  logic sda_oe_r;
  logic scl_oe_r;
  logic [23:0] cnt_r;
  logic play_r;
  logic abort_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic exec_c;
  logic [15:0] tx_nxt;

  // pins are asynchronous to i_clk
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
    end else begin
      {scl_m_r, scl_s_r, scl_d_r} <= {bus.scl, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {bus.sda, sda_m_r, sda_s_r};
    end
  end

  // oversampling at 200 MHz keeps up with both bus rates
  assign scl_rise = scl_s_r && !scl_d_r;
  assign scl_fall = !scl_s_r && scl_d_r;
  assign start_c = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign stop_c = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  // command acts at stop, or at repeated start for the revision read
  assign exec_c = (start_c || stop_c) && (nbytes_r == 2'h2) && !rw_r;
  assign tx_nxt = {tx_r[14:0], 1'b0};

  // never pull the clock except to stretch; data only pulled low
  assign bus.scl_s_o = 1'b0;
  assign bus.scl_s_oe = scl_oe_r;
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_oe_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r <= D_IDLE;
      shift_r <= 8'h00;
      bit_r <= 4'h0;
      rw_r <= 1'b0;
      nbytes_r <= 2'h0;
      cmd0_r <= 8'h00;
      cmd1_r <= 8'h00;
      tx_r <= 16'h0000;
      more_r <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
      cnt_r <= 24'h000000;
    end else begin
      if (exec_c && cmd0_r == CMD_REV) begin
        tx_r <= REV_VALUE;
      end
      if (start_c) begin
        // no collision check here: a start is never contested by this end
        state_r <= D_ADDR;
        bit_r <= 4'h0;
        nbytes_r <= 2'h0;
        sda_oe_r <= 1'b0;
        scl_oe_r <= 1'b0;
      end else if (stop_c) begin
        state_r <= D_IDLE;
        nbytes_r <= 2'h0;
        sda_oe_r <= 1'b0;
        scl_oe_r <= 1'b0;
      end else begin
        case (state_r)
          D_ADDR, D_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s_r};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              if (state_r == D_ADDR) begin
                // general call and ten-bit headers never equal the address
                if (shift_r[7:1] == SLAVE_ADDR) begin
                  sda_oe_r <= 1'b1;
                  rw_r <= shift_r[0];
                  state_r <= D_ACK;
                end else begin
                  state_r <= D_IDLE;
                end
              end else if (nbytes_r != 2'h2) begin
                if (nbytes_r == 2'h0) begin
                  cmd0_r <= shift_r;
                end else begin
                  cmd1_r <= shift_r;
                end
                nbytes_r <= nbytes_r + 2'h1;
                sda_oe_r <= 1'b1;
                state_r <= D_ACK;
              end else begin
                state_r <= D_IDLE;
              end
            end
          end
          D_ACK: begin
            if (scl_fall) begin
              bit_r <= 4'h0;
              if (rw_r) begin
                sda_oe_r <= !tx_r[15];
                state_r <= D_TX;
              end else begin
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b1;
                cnt_r <= 24'h000000;
                state_r <= D_STRETCH;
              end
            end
          end
          D_STRETCH: begin
            cnt_r <= cnt_r + 24'h000001;
            if (cnt_r == STRETCH_CYC - 24'h000001) begin
              scl_oe_r <= 1'b0;
            end
            if (cnt_r == 24'(STRETCH_TO - 1)) begin
              scl_oe_r <= 1'b0;
              nbytes_r <= 2'h0;
              state_r <= D_IDLE;
            end else if (scl_rise && !scl_oe_r) begin
              shift_r <= {shift_r[6:0], sda_s_r};
              bit_r <= 4'h1;
              state_r <= D_RX;
            end
          end
          D_TX: begin
            if (scl_rise && !sda_oe_r && !sda_s_r) begin
              sda_oe_r <= 1'b0;
              nbytes_r <= 2'h0;
              state_r <= D_IDLE;
            end else if (scl_fall) begin
              tx_r <= tx_nxt;
              if (bit_r == 4'h7) begin
                sda_oe_r <= 1'b0;
                state_r <= D_MACK;
              end else begin
                sda_oe_r <= !tx_nxt[15];
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          D_MACK: begin
            if (scl_rise) begin
              more_r <= !sda_s_r;
            end else if (scl_fall) begin
              bit_r <= 4'h0;
              if (more_r) begin
                sda_oe_r <= !tx_r[15];
                state_r <= D_TX;
              end else begin
                state_r <= D_IDLE;
              end
            end
          end
          default: begin
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // one-cycle requests to the player
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      play_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      play_r <= exec_c && cmd0_r == CMD_EFFECT && cmd1_r < {4'h0, NUM_EFFECTS};
      abort_r <= exec_c && cmd0_r == CMD_ABORT;
    end
  end

  hap_player #(
    .VIB_HALF(VIB_HALF)
  ) u_player (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_play(play_r),
    .i_effect(cmd1_r[3:0]),
    .i_abort(abort_r),
    .o_drive_true(o_pwm_drive_true),
    .o_drive_inv(o_pwm_drive_inverted),
    .o_busy(o_effect_busy)
  );
endmodule

// ==== hdl/hap_host.sv ====
// bus master end: sends two-byte commands and reads the revision
`timescale 1ns/1ps
module hap_host
  import hap_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  hap_if.host bus,
  input wire logic i_go,
  input wire logic [7:0] i_byte0,
  input wire logic [7:0] i_byte1,
  input wire logic i_read_rev,
  input wire logic i_fast_mode,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic [15:0] o_rev
);
  hap_hst_t state_r;
  logic scl_m_r;
  logic scl_s_r;
  logic sda_m_r;
  logic sda_s_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic [8:0] qcnt_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [2:0] bi_r;
  logic [7:0] sh_r;
  logic [7:0] b0_r;
  logic [7:0] b1_r;
  logic rd_r;
  logic [15:0] rx_r;
  logic ack_in_r;
  logic [8:0] qtr;
  logic stalled;
  logic tick;

  function automatic logic [7:0] byte_for(input logic [2:0] bi, input logic [7:0] b0,
                                          input logic [7:0] b1);
    case (bi)
      3'h0: byte_for = {SLAVE_ADDR, 1'b0};
      3'h1: byte_for = b0;
      3'h2: byte_for = b1;
      3'h3: byte_for = {SLAVE_ADDR, 1'b1};
      default: byte_for = 8'hFF;
    endcase
  endfunction

  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe = scl_oe_r;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_oe_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      {scl_m_r, scl_s_r} <= 2'h3;
      {sda_m_r, sda_s_r} <= 2'h3;
    end else begin
      {scl_m_r, scl_s_r} <= {bus.scl, scl_m_r};
      {sda_m_r, sda_s_r} <= {bus.sda, sda_m_r};
    end
  end

  assign qtr = i_fast_mode ? QTR_FAST : QTR_STD;
  // clock released but still low: the slave is stretching, so time stands still
  assign stalled = !scl_oe_r && !scl_s_r;
  assign tick = (qcnt_r == qtr - 9'h001) && !stalled;

  always_ff @(posedge i_clk) begin
    if (i_srst || state_r == H_IDLE || tick) begin
      qcnt_r <= 9'h000;
    end else if (!stalled) begin
      qcnt_r <= qcnt_r + 9'h001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r <= H_IDLE;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      bi_r <= 3'h0;
      sh_r <= 8'h00;
      b0_r <= 8'h00;
      b1_r <= 8'h00;
      rd_r <= 1'b0;
      rx_r <= 16'h0000;
      ack_in_r <= 1'b1;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_nack <= 1'b0;
      o_rev <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      case (state_r)
        H_IDLE: begin
          if (i_go) begin
            state_r <= H_START;
            o_busy <= 1'b1;
            o_nack <= 1'b0;
            b0_r <= i_byte0;
            b1_r <= i_byte1;
            rd_r <= i_read_rev;
            bi_r <= 3'h0;
            sh_r <= byte_for(3'h0, i_byte0, i_byte1);
            ph_r <= 2'h0;
          end
        end
        H_START: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h0) begin
              sda_oe_r <= 1'b1;
            end else begin
              scl_oe_r <= 1'b1;
              state_r <= H_BIT;
              bit_r <= 4'h0;
              ph_r <= 2'h0;
            end
          end
        end
        H_BIT: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              // data moves only in the low half of the clock
              2'h0: begin
                if (bit_r != 4'h8) begin
                  sda_oe_r <= (bi_r < 3'h4) && !sh_r[7];
                end else begin
                  sda_oe_r <= (bi_r == 3'h4);
                end
              end
              2'h1: scl_oe_r <= 1'b0;
              2'h2: begin
                if (bit_r == 4'h8) begin
                  ack_in_r <= sda_s_r;
                end else begin
                  sh_r <= {sh_r[6:0], 1'b0};
                  rx_r <= {rx_r[14:0], sda_s_r};
                end
              end
              default: begin
                scl_oe_r <= 1'b1;
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h8) begin
                  bit_r <= 4'h0;
                  bi_r <= bi_r + 3'h1;
                  sh_r <= byte_for(bi_r + 3'h1, b0_r, b1_r);
                  if (bi_r < 3'h4 && ack_in_r) begin
                    o_nack <= 1'b1;
                    state_r <= H_STOP;
                  end else if (bi_r == 3'h2 && rd_r) begin
                    state_r <= H_RSTART;
                  end else if (bi_r == 3'h2 || bi_r == 3'h5) begin
                    state_r <= H_STOP;
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h0) begin
              sda_oe_r <= 1'b1;
            end else if (ph_r == 2'h1) begin
              scl_oe_r <= 1'b0;
            end else begin
              sda_oe_r <= 1'b0;
              state_r <= H_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
              if (bi_r == 3'h6) begin
                o_rev <= rx_r;
              end
            end
          end
        end
        H_RSTART: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h0) begin
              sda_oe_r <= 1'b0;
            end else begin
              scl_oe_r <= 1'b0;
              state_r <= H_START;
              ph_r <= 2'h0;
            end
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end
endmodule

// ==== hdl/hap_player.sv ====
// effect library and complementary pwm drive generator
`timescale 1ns/1ps
module hap_player
  import hap_pkg::*;
#(
  parameter int unsigned VIB_HALF = hap_pkg::VIB_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_play,
  input wire logic [3:0] i_effect,
  input wire logic i_abort,
  output logic o_drive_true,
  output logic o_drive_inv,
  output logic o_busy
);
  logic [18:0] ph_cnt_r;
  logic [7:0] halves_r;
  logic [7:0] total_r;
  logic [9:0] peak_r;
  logic decay_r;
  logic pol_r;
  logic [3:0] pre_r;
  logic [9:0] pwm_cnt_r;
  logic [9:0] amp;
  logic [9:0] duty;
  logic [18:0] entry;

  // {peak amplitude, duration in vibration half periods, decays}
  function automatic logic [18:0] effect_entry(input logic [3:0] idx);
    case (idx)
      4'h0: effect_entry = {10'h3FF, 8'h04, 1'b0};
      4'h1: effect_entry = {10'h2FF, 8'h04, 1'b0};
      4'h2: effect_entry = {10'h1FF, 8'h04, 1'b0};
      4'h3: effect_entry = {10'h3FF, 8'h0A, 1'b1};
      4'h4: effect_entry = {10'h2FF, 8'h0A, 1'b1};
      4'h5: effect_entry = {10'h1FF, 8'h0A, 1'b1};
      4'h6: effect_entry = {10'h3FF, 8'h14, 1'b0};
      4'h7: effect_entry = {10'h2FF, 8'h14, 1'b0};
      4'h8: effect_entry = {10'h3FF, 8'h28, 1'b1};
      4'h9: effect_entry = {10'h2FF, 8'h28, 1'b1};
      4'hA: effect_entry = {10'h3FF, 8'h02, 1'b0};
      4'hB: effect_entry = {10'h27F, 8'h50, 1'b1};
      default: effect_entry = {10'h17F, 8'h50, 1'b0};
    endcase
  endfunction

  // a function result cannot be part-selected, so the table entry is held on a net
  assign entry = effect_entry(i_effect);

  // decaying effects drop to half amplitude once fewer than half of their half periods remain
  assign amp = (decay_r && (halves_r < {1'b0, total_r[7:1]})) ? {1'b0, peak_r[9:1]} : peak_r;
  assign duty = pol_r ? DUTY_MID + {1'b0, amp[9:1]} : DUTY_MID - {1'b0, amp[9:1]};

  always_ff @(posedge i_clk) begin
    if (i_srst || i_abort) begin
      o_busy <= 1'b0;
      halves_r <= 8'h00;
      ph_cnt_r <= '0;
      pol_r <= 1'b0;
    end else if (i_play) begin
      o_busy <= 1'b1;
      {peak_r, halves_r, decay_r} <= entry;
      total_r <= entry[8:1];
      ph_cnt_r <= '0;
      pol_r <= 1'b1;
    end else if (o_busy) begin
      // alternate drive direction every half period for a 200 Hz vibration
      if (ph_cnt_r == 19'(VIB_HALF - 1)) begin
        ph_cnt_r <= '0;
        pol_r <= ~pol_r;
        halves_r <= halves_r - 8'h01;
        if (halves_r == 8'h01) begin
          o_busy <= 1'b0;
        end
      end else begin
        ph_cnt_r <= ph_cnt_r + 19'h00001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pre_r <= 4'h0;
      pwm_cnt_r <= 10'h000;
    end else if (pre_r == PWM_DIV - 4'h1) begin
      pre_r <= 4'h0;
      pwm_cnt_r <= pwm_cnt_r + 10'h001;
    end else begin
      pre_r <= pre_r + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_drive_true <= 1'b0;
      o_drive_inv <= 1'b1;
    end else begin
      o_drive_true <= o_busy && !i_abort && (pwm_cnt_r < duty);
      o_drive_inv <= !(o_busy && !i_abort && (pwm_cnt_r < duty));
    end
  end
endmodule

// ==== testbench/hap_link_asserts.sv ====
// concurrent checks on the serial link and drive pair of the controller
`timescale 1ns/1ps
module hap_link_asserts
  import hap_pkg::*;
#(
  parameter int unsigned STRETCH_TO = 2000
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_s_o,
  input wire logic scl_s_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic o_pwm_drive_true,
  input wire logic o_pwm_drive_inverted,
  input wire logic o_effect_busy
);
  // length of the current clock hold by the controller
  logic [23:0] hold_r;
  always_ff @(posedge i_clk) begin
    if (i_srst || !scl_s_oe) begin
      hold_r <= 24'h0;
    end else begin
      hold_r <= hold_r + 24'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  AST_INV_PAIR: assert property (o_pwm_drive_inverted == !o_pwm_drive_true)
    else $error("drive pair not complementary");
  AST_IDLE_STATIC: assert property (
    !o_effect_busy && !$past(o_effect_busy) |-> !o_pwm_drive_true)
    else $error("drive switching while idle");
  AST_SDA_OPEN_DRAIN: assert property (sda_s_oe |-> !sda_s_o)
    else $error("data line driven high");
  AST_SCL_OPEN_DRAIN: assert property (scl_s_oe |-> !scl_s_o)
    else $error("clock line driven high");
  AST_SDA_STABLE_HIGH: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("data changed while clock high");
  AST_STRETCH_AFTER_LOW: assert property ($rose(scl_s_oe) |-> !$past(scl))
    else $error("stretch began while clock high");
  AST_STRETCH_LEN: assert property (
    $fell(scl_s_oe) |-> $past(hold_r) == STRETCH_CYC - 24'h000001)
    else $error("stretch length wrong");
  AST_STRETCH_LIMIT: assert property (hold_r <= 24'(STRETCH_TO))
    else $error("stretch beyond time-out");
  AST_BIT_HOLD: assert property ($rose(sda_s_oe) |-> sda_s_oe [*8])
    else $error("driven bit too short");
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench: host and controller back to back, plus a bit-level driver
`timescale 1ns/1ps
module testbench;
  import hap_pkg::*;
  // short time-out and vibration half period keep the run brief
  localparam int unsigned STO = 2000;
  // every effect outlasts the abort frame that follows it
  localparam int unsigned VH = 16384;
  localparam int unsigned QTR = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0;
  logic [7:0] b0 = 8'h00;
  logic [7:0] b1 = 8'h00;
  logic rd = 1'b0;
  logic fast = 1'b1;
  logic h_busy, h_done, h_nack, eb, dt, di;
  logic [15:0] h_rev;
  int failures = 0;
  int checks_done = 0;
  hap_if bus ();
  hap_if bus2 ();
  hap_host i_hap_host (.i_clk(clk), .i_srst(srst), .bus(bus), .i_go(go), .i_byte0(b0),
    .i_byte1(b1), .i_read_rev(rd), .i_fast_mode(fast), .o_busy(h_busy), .o_done(h_done),
    .o_nack(h_nack), .o_rev(h_rev));
  hap_dev #(.STRETCH_TO(STO), .VIB_HALF(VH)) i_hap_dev (.i_clk(clk), .i_srst(srst),
    .bus(bus), .o_pwm_drive_true(dt), .o_pwm_drive_inverted(di), .o_effect_busy(eb));
  // second controller faces a driver that breaks the master's rules on purpose
  hap_dev #(.STRETCH_TO(STO), .VIB_HALF(VH)) i_hap_dev_b (.i_clk(clk), .i_srst(srst),
    .bus(bus2), .o_pwm_drive_true(), .o_pwm_drive_inverted(), .o_effect_busy());
  hap_link_asserts #(.STRETCH_TO(STO)) i_hap_link_asserts (.i_clk(clk), .i_srst(srst),
    .scl(bus.scl), .sda(bus.sda), .scl_s_o(bus.scl_s_o), .scl_s_oe(bus.scl_s_oe),
    .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe), .o_pwm_drive_true(dt),
    .o_pwm_drive_inverted(di), .o_effect_busy(eb));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // a play request starts an effect only for an in-range index
  function automatic logic exp_busy(input logic [7:0] c0, input logic [7:0] c1);
    return (c0 == CMD_EFFECT) && (c1 < {4'h0, NUM_EFFECTS});
  endfunction

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic frame(input logic [7:0] c0, input logic [7:0] c1, input logic r,
                       input logic f);
    int n;
    @(posedge clk);
    b0 <= c0;
    b1 <= c1;
    rd <= r;
    fast <= f;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (h_done !== 1'b1 && n < 120000) begin
      @(negedge clk);
      n++;
    end
    chk(h_done, 1'b1, "frame did not complete");
    chk(h_busy, 1'b0, "master still busy at done");
    chk(h_nack, 1'b0, "command byte refused");
    repeat (10) @(negedge clk);
  endtask

  // one quarter bit on the second link; 1 means released
  task automatic quarter(input logic c, input logic d);
    bus2.scl_m_oe <= !c;
    bus2.sda_m_oe <= !d;
    repeat (QTR) @(posedge clk);
  endtask

  task automatic send_byte(input logic [7:0] v, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      quarter(1'b0, i == 0 ? 1'b1 : v[i - 1]);
      quarter(1'b1, i == 0 ? 1'b1 : v[i - 1]);
      quarter(1'b1, i == 0 ? 1'b1 : v[i - 1]);
      ack = bus2.sda;
      quarter(1'b0, i == 0 ? 1'b1 : v[i - 1]);
    end
  endtask

  task automatic start2();
    quarter(1'b1, 1'b1);
    quarter(1'b1, 1'b0);
    quarter(1'b0, 1'b0);
  endtask

  task automatic stop2();
    quarter(1'b0, 1'b0);
    quarter(1'b1, 1'b0);
    quarter(1'b1, 1'b1);
  endtask

  initial begin
    repeat (140000) @(posedge clk);
    failures++;
    $display("CHECK FAILED at %0t: run took too long", $time);
    test_done();
  end

  initial begin
    logic [3:0] idx;
    logic ack;
    logic [7:0] addr [3];
    logic prev;
    int n;
    bus2.scl_m_o = 1'b0;
    bus2.sda_m_o = 1'b0;
    bus2.scl_m_oe = 1'b0;
    bus2.sda_m_oe = 1'b0;
    void'($urandom(32'h29f2));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    chk({eb, dt, di}, 16'h1, "drive not idle after reset");
    // general call and ten-bit lead-in are refused, own address taken
    addr = '{8'h00, 8'hF0, {SLAVE_ADDR, 1'b0}};
    for (int k = 0; k < 3; k++) begin
      start2();
      send_byte(addr[k], ack);
      chk(ack, k == 2 ? 1'b0 : 1'b1, "address answer wrong");
      if (k < 2) begin
        stop2();
      end
    end
    // master keeps the clock low past the time-out; controller must give up
    repeat (STO + 400) @(posedge clk);
    chk(bus2.scl_s_oe, 1'b0, "clock still held");
    send_byte(CMD_EFFECT, ack);
    chk(ack, 1'b1, "interface not reset by time-out");
    stop2();
    // random effect in fast mode
    idx = 4'($urandom % 13);
    frame(CMD_EFFECT, {4'h0, idx}, 1'b0, 1'b1);
    chk(eb, exp_busy(CMD_EFFECT, {4'h0, idx}), "effect not started");
    prev = dt;
    n = 0;
    while (dt === prev && n < 4200) begin
      @(negedge clk);
      n++;
    end
    chk(dt, !prev, "no pwm switching during effect");
    frame(CMD_ABORT, 8'($urandom), 1'b0, 1'b1);
    chk({eb, dt, di}, 16'h1, "abort left drive active");
    frame(CMD_REV, 8'($urandom), 1'b1, 1'b1);
    chk(h_rev, REV_VALUE, "revision value wrong");
    // out-of-range index in standard mode is taken but plays nothing
    frame(CMD_EFFECT, 8'h0D, 1'b0, 1'b0);
    chk(eb, exp_busy(CMD_EFFECT, 8'h0D), "invalid effect played");
    test_done();
  end
endmodule
